// *** include/meis_consts.svh ***
// constants of the external interrupt source block
`ifndef MEIS_CONSTS_SVH
`define MEIS_CONSTS_SVH
// register indices: the byte address is four times the index
`define MEIS_IDX_CHMODE 8'h16
`define MEIS_IDX_CICLR 8'h46
`define MEIS_IDX_CFG2 8'h4a
`define MEIS_IDX_CAUSE1 8'h41
`define MEIS_IDX_CAUSE2 8'h42
`define MEIS_IDX_MASK1 8'h43
`define MEIS_IDX_MASK2 8'h44
`define MEIS_IDX_CFG1 8'h40
`define MEIS_IDX_VIDST 8'h47
`define MEIS_IDX_TEMP 8'h48
`define MEIS_IDX_DACSET 8'h49
`define MEIS_IDX_DACOUT 8'h4b
// field positions
`define MEIS_CHMODE_GRPDIS 7
`define MEIS_CFG1_INTEN 1
`define MEIS_CFG1_INTCLR 3
`define MEIS_CICLR_GO 7
`define MEIS_CAUSE2_CI 4
`define MEIS_CAUSE2_OVERHEAT_LINE_N 5
`define MEIS_CAUSE2_D1 6
`define MEIS_CAUSE2_D2 7
`define MEIS_CFG2_IRQ3EN 4
`define MEIS_CFG2_IRQ4EN 5
// reset values
`define MEIS_RST_MASK 8'hff
`define MEIS_RST_ZERO 8'h00
// timing, diode readings and dac full scale
`define MEIS_CI_PULSE_MS 20
`define MEIS_CLK_HZ 100000000
`define MEIS_TEMP_OPEN 8'h7f
`define MEIS_TEMP_SHORT 8'h00
`define MEIS_DAC_FULL 8'hff
`endif

// *** include/meis_pkg.sv ***
// types of the external interrupt source block
package meis_pkg;
  typedef enum logic [1:0] {
    MEIS_CI_IDLE = 2'b01,
    MEIS_CI_PULSE = 2'b10
  } meis_ci_e;
  typedef enum logic [2:0] {
    MEIS_DIODE_OK = 3'b001,
    MEIS_DIODE_OPEN = 3'b010,
    MEIS_DIODE_SHORT = 3'b100
  } meis_diode_e;
endpackage

// *** verilog/meis_top.sv ***
// external interrupt sources, diode check and intrusion reset pulse
`timescale 1ns/1ns
`include "meis_consts.svh"
module meis_top
  import meis_pkg::*;
#(
  parameter int CI_PULSE_CYC =
    (`MEIS_CI_PULSE_MS * (`MEIS_CLK_HZ / 1000)),
  parameter int REQ_WIDTH = 5
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [9:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [9:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic convDone,
  input wire logic [1:0] diodeOpen,
  input wire logic [1:0] diodeShort,
  input wire logic [15:0] remoteTemp,
  input wire logic limitOverheat,
  input wire logic [7:0] otherCause1,
  input wire logic [3:0] otherCause2,
  input wire logic [REQ_WIDTH-1:0] extRequestPins,
  input wire logic chassisIntrusionIn,
  output logic chassisIntrusionOut,
  output logic chassisIntrusionOe,
  input wire logic overheatLineIn,
  output logic overheatLineOut,
  output logic overheatLineOe,
  output logic [7:0] dacOut,
  output logic intOut_n
);

  // ****************************************************
  // input synchronisers
  // ****************************************************
  logic [REQ_WIDTH-1:0] reqMeta, voltageIdStatus;
  logic ciMeta, ciSync, thMeta, thSync;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reqMeta <= '0;
      voltageIdStatus <= '0;
      ciMeta <= 1'b0;
      ciSync <= 1'b0;
      thMeta <= 1'b1;
      thSync <= 1'b1;
    end else if (clkEn) begin
      reqMeta <= extRequestPins;
      voltageIdStatus <= reqMeta;
      ciMeta <= chassisIntrusionIn;
      ciSync <= ciMeta;
      thMeta <= overheatLineIn;
      thSync <= thMeta;
    end
  end

  // ****************************************************
  // own overheat drive, aligned with the synchronised line
  // ****************************************************
  // without this the two-cycle sync lag reads our own released
  // pull-low as an external one
  logic ohOeDly1, ohOeDly2;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ohOeDly1 <= 1'b0;
      ohOeDly2 <= 1'b0;
    end else if (clkEn) begin
      ohOeDly1 <= overheatLineOe;
      ohOeDly2 <= ohOeDly1;
    end
  end
  logic extHotSeen;
  assign extHotSeen = !thSync && !ohOeDly2 && !overheatLineOe;

  // ****************************************************
  // registers
  // ****************************************************
  logic [7:0] channelMode, configTwo, configOne, mask1, mask2;
  logic [7:0] cause1, cause2, dacSetting, reportTemp1, reportTemp2;
  logic ciGo;
  meis_ci_e ciState;
  logic [31:0] ciCount;
  logic wrFire, rdFire, awHeld, wHeld;
  logic [7:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;

  function automatic logic [7:0] addrIdx(input logic [9:0] a);
    addrIdx = a[9:2];
  endfunction

  function automatic logic mapped(input logic [7:0] i);
    unique case (i)
      `MEIS_IDX_CHMODE, `MEIS_IDX_CICLR, `MEIS_IDX_CFG2,
      `MEIS_IDX_CAUSE1, `MEIS_IDX_CAUSE2, `MEIS_IDX_MASK1,
      `MEIS_IDX_MASK2, `MEIS_IDX_CFG1, `MEIS_IDX_VIDST,
      `MEIS_IDX_TEMP, `MEIS_IDX_DACSET, `MEIS_IDX_DACOUT:
        mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // write channel: address and data may arrive in either order
  // ready stays low until the response is taken: one write at a time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= '0;
      wStrbQ <= '0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end else if (clkEn) begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awready <= 1'b0;
        awAddrQ <= addrIdx(awaddr);
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wready <= 1'b0;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(awAddrQ) ? 2'b00 : 2'b10;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end
  assign wrFire = awHeld && wHeld && !bvalid;

  logic wrByte0;
  assign wrByte0 = wrFire && wStrbQ[0];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      channelMode <= `MEIS_RST_ZERO;
      configTwo <= `MEIS_RST_ZERO;
      configOne <= `MEIS_RST_ZERO;
      mask1 <= `MEIS_RST_MASK;
      mask2 <= `MEIS_RST_MASK;
      dacSetting <= `MEIS_RST_ZERO;
    end else if (clkEn && wrByte0) begin
      unique case (awAddrQ)
        `MEIS_IDX_CHMODE: channelMode <= wDataQ[7:0];
        `MEIS_IDX_CFG2: configTwo <= wDataQ[7:0];
        `MEIS_IDX_CFG1: configOne <= wDataQ[7:0];
        `MEIS_IDX_MASK1: mask1 <= wDataQ[7:0];
        `MEIS_IDX_MASK2: mask2 <= wDataQ[7:0];
        `MEIS_IDX_DACSET: dacSetting <= wDataQ[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************************
  // intrusion reset pulse
  // ****************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ciGo <= 1'b0;
      ciState <= MEIS_CI_IDLE;
      ciCount <= '0;
      chassisIntrusionOe <= 1'b0;
    end else if (clkEn) begin
      unique case (ciState)
        MEIS_CI_IDLE: begin
          if (wrByte0 && awAddrQ == `MEIS_IDX_CICLR &&
              wDataQ[`MEIS_CICLR_GO]) begin
            ciGo <= 1'b1;
            ciState <= MEIS_CI_PULSE;
            ciCount <= '0;
            chassisIntrusionOe <= 1'b1;
          end
        end
        MEIS_CI_PULSE: begin
          // a second clear during the pulse does not restart it
          ciGo <= 1'b0;
          ciCount <= ciCount + 32'h1;
          if (ciCount >= 32'(CI_PULSE_CYC - 1)) begin
            ciState <= MEIS_CI_IDLE;
            chassisIntrusionOe <= 1'b0;
          end
        end
      endcase
    end
  end
  assign chassisIntrusionOut = 1'b0;

  // ****************************************************
  // diode check and cause registers
  // ****************************************************
  logic [1:0] diodeFault;
  logic ciEvent, thEvent, rdCause1, rdCause2;
  logic [7:0] set1, set2;
  assign thEvent = extHotSeen;
  assign ciEvent = ciSync && !chassisIntrusionOe;
  assign diodeFault = diodeOpen;
  assign set1 = convDone ? otherCause1 : 8'h00;
  assign set2 = {diodeFault[1] & convDone, diodeFault[0] & convDone,
                 thEvent, ciEvent, otherCause2 & {4{convDone}}};

  function automatic logic [7:0] diodeRead(input logic isOpen,
      input logic isShort, input logic [7:0] raw);
    if (isOpen) diodeRead = `MEIS_TEMP_OPEN;
    else if (isShort) diodeRead = `MEIS_TEMP_SHORT;
    else diodeRead = raw;
  endfunction

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reportTemp1 <= `MEIS_TEMP_SHORT;
      reportTemp2 <= `MEIS_TEMP_SHORT;
    end else if (clkEn && convDone) begin
      reportTemp1 <= diodeRead(diodeOpen[0], diodeShort[0],
        remoteTemp[7:0]);
      reportTemp2 <= diodeRead(diodeOpen[1], diodeShort[1],
        remoteTemp[15:8]);
    end
  end

  // set wins over a clearing read in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cause1 <= `MEIS_RST_ZERO;
      cause2 <= `MEIS_RST_ZERO;
    end else if (clkEn) begin
      cause1 <= (rdCause1 ? 8'h00 : cause1) | set1;
      cause2 <= (rdCause2 ? 8'h00 : cause2) | set2;
    end
  end

  // ****************************************************
  // read channel
  // ****************************************************
  logic [7:0] rdIdx;
  assign rdIdx = addrIdx(araddr);
  assign rdFire = arvalid && arready;
  assign rdCause1 = clkEn && rdFire && rdIdx == `MEIS_IDX_CAUSE1;
  assign rdCause2 = clkEn && rdFire && rdIdx == `MEIS_IDX_CAUSE2;

  logic [7:0] rdVal;
  always_comb begin
    rdVal = 8'h00;
    unique case (rdIdx)
      `MEIS_IDX_CHMODE: rdVal = channelMode;
      `MEIS_IDX_CICLR: rdVal = {ciGo, 7'h00};
      `MEIS_IDX_CFG2: rdVal = configTwo;
      `MEIS_IDX_CFG1: rdVal = configOne;
      `MEIS_IDX_CAUSE1: rdVal = cause1;
      `MEIS_IDX_CAUSE2: rdVal = cause2;
      `MEIS_IDX_MASK1: rdVal = mask1;
      `MEIS_IDX_MASK2: rdVal = mask2;
      `MEIS_IDX_VIDST: rdVal = 8'(voltageIdStatus);
      `MEIS_IDX_TEMP: rdVal = reportTemp1;
      `MEIS_IDX_DACSET: rdVal = dacSetting;
      `MEIS_IDX_DACOUT: rdVal = reportTemp2;
      default: rdVal = 8'h00;
    endcase
  end

  // arready low while rdata stands: one read at a time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= 2'b00;
    end else if (clkEn) begin
      if (rdFire) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h000000, rdVal};
        rresp <= mapped(rdIdx) ? 2'b00 : 2'b10;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ****************************************************
  // interrupt, overheat line and dac
  // ****************************************************
  logic grpEn, reqHit, causeHit, next_intOut_n;
  assign grpEn = !channelMode[`MEIS_CHMODE_GRPDIS];
  // low requests ignore the masks by design
  assign reqHit = grpEn && (
    |(~voltageIdStatus[2:0] & channelMode[2:0]) ||
    (voltageIdStatus[3] && channelMode[3] &&
     configTwo[`MEIS_CFG2_IRQ3EN]) ||
    (voltageIdStatus[4] && channelMode[4] &&
     configTwo[`MEIS_CFG2_IRQ4EN]));
  assign causeHit = |(cause1 & ~mask1) || |(cause2 & ~mask2);
  assign next_intOut_n = !(configOne[`MEIS_CFG1_INTEN] &&
    !configOne[`MEIS_CFG1_INTCLR] &&
    (reqHit || causeHit));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      intOut_n <= 1'b1;
    end else if (clkEn) begin
      intOut_n <= next_intOut_n;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      overheatLineOe <= 1'b0;
    end else if (clkEn) begin
      overheatLineOe <= limitOverheat;
    end
  end

  // full scale at reset and while extHotSeen is high; other enabled cycles load dacSetting, zero until software writes it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dacOut <= `MEIS_DAC_FULL;
    end else if (clkEn) begin
      dacOut <= extHotSeen ?
        `MEIS_DAC_FULL : dacSetting;
    end
  end
  assign overheatLineOut = 1'b0;

endmodule // meis_top

// *** tb/meis_chk_monitor.sv ***
// port checker of the external interrupt source block
`timescale 1ns/1ns
module meis_chk #(
  parameter int CI_PULSE_CYC = 50
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic awready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic limitOverheat,
  input wire logic chassisIntrusionOut,
  input wire logic chassisIntrusionOe,
  input wire logic overheatLineIn,
  input wire logic overheatLineOe,
  input wire logic [7:0] dacOut
);
  // ****************
  // assertions
  // ****************
  // counter, since the pulse is far too long for a repetition
  int ciCnt;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ciCnt <= 0;
    end else begin
      ciCnt <= chassisIntrusionOe ? ciCnt + 1 : 0;
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_pulse_len: assert property (
    $fell(chassisIntrusionOe) |-> ciCnt == CI_PULSE_CYC)
    else $error("intrusion pulse length");
  a_ci_pull_low: assert property (
    chassisIntrusionOe |-> !chassisIntrusionOut)
    else $error("intrusion line not low");
  a_dac_forced: assert property (
    (!overheatLineIn && !overheatLineOe)[*4] |-> dacOut == 8'hff)
    else $error("dac not full scale");
  a_oh_follow: assert property (
    limitOverheat |=> overheatLineOe)
    else $error("overheat drive missing");
  a_oh_quiet: assert property (
    !limitOverheat |=> !overheatLineOe)
    else $error("overheat drive spurious");
  a_ar_answer: assert property (
    arvalid && arready && clkEn |=> rvalid)
    else $error("read answer late");
  a_aw_block: assert property (
    bvalid |-> !awready)
    else $error("awready during response");
  a_ar_block: assert property (
    rvalid |-> !arready)
    else $error("arready during response");
endmodule // meis_chk
bind meis_top meis_chk #(.CI_PULSE_CYC(CI_PULSE_CYC)) u_chk (
  .clk_sys, .rst, .clkEn, .awready, .bvalid, .arvalid, .arready,
  .rvalid, .limitOverheat, .chassisIntrusionOut, .chassisIntrusionOe,
  .overheatLineIn, .overheatLineOe, .dacOut);

// *** tb/meis_src_model.sv ***
// model of intrusion latch, thermal supervisor and request sources
`timescale 1ns/1ns
module meis_src (
  input wire logic intrude,
  input wire logic extHot,
  input wire logic [4:0] reqLevel,
  input wire logic ciOe,
  input wire logic ciOut,
  input wire logic ohOe,
  input wire logic ohOut,
  output logic ciLine,
  output logic ohLine,
  output logic [4:0] reqPins
);
  // ****************
  // far side
  // ****************
  logic latched = 1'b0;
  // latch holds until the device pulls the line low
  always @(posedge intrude or posedge ciOe) begin
    latched <= !ciOe;
  end
  assign ciLine = (ciOe && !ciOut) ? 1'b0 : latched;
  // pull-up, either party may pull low
  assign ohLine = !((ohOe && !ohOut) || extHot);
  assign reqPins = reqLevel;
endmodule // meis_src

// *** tb/tb_top.sv ***
// bench of the external interrupt source block
`timescale 1ns/1ns
`include "meis_consts.svh"
`define CHK(n, e, g) begin \
  checksDone++; \
  if ((g) !== (e)) begin \
    errTotal++; \
    $display("[ERR] %s exp %h got %h", n, e, g); \
  end \
end
module tb_top;
  // ****************
  // stimulus
  // ****************
  localparam int PULSE = 50;
  int errTotal = 0;
  int checksDone = 0;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [9:0] awaddr = 10'h000;
  logic [9:0] araddr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, convDone = 1'b0;
  logic [1:0] diodeOpen = 2'h0, diodeShort = 2'h0;
  logic [15:0] remoteTemp = 16'h3355;
  logic limitOverheat = 1'b0, intrude = 1'b0, extHot = 1'b0;
  logic [7:0] otherCause1 = 8'h00;
  logic [3:0] otherCause2 = 4'h0;
  logic [4:0] reqLevel = 5'b00111;
  logic [4:0] extRequestPins;
  logic chassisIntrusionIn, overheatLineIn, intOut_n;
  logic awready, wready, bvalid, arready, rvalid;
  logic chassisIntrusionOut, chassisIntrusionOe;
  logic overheatLineOut, overheatLineOe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] dacOut;
  always #5 clk_sys = ~clk_sys;
  meis_top #(.CI_PULSE_CYC(PULSE)) i_dut (.*);
  meis_src i_src (.intrude(intrude), .extHot(extHot),
    .reqLevel(reqLevel), .ciOe(chassisIntrusionOe),
    .ciOut(chassisIntrusionOut), .ohOe(overheatLineOe),
    .ohOut(overheatLineOut), .ciLine(chassisIntrusionIn),
    .ohLine(overheatLineIn), .reqPins(extRequestPins));
  task tick(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    awaddr <= {a, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bvalid && n < 50) begin
      @(posedge clk_sys);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    `CHK("bvalid", 1'b1, bvalid)
    `CHK("bresp", 2'b00, bresp)
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e,
          input logic [1:0] r = 2'b00);
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rvalid && n < 50) begin
      @(posedge clk_sys);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata[7:0])
    `CHK("rresp", r, rresp)
    rready <= 1'b0;
  endtask
  task conv;
    @(posedge clk_sys);
    convDone <= 1'b1;
    @(posedge clk_sys);
    convDone <= 1'b0;
  endtask
  task intIs(input logic e);
    tick(5);
    `CHK("intOut_n", e, intOut_n)
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", errTotal, checksDone);
    if (errTotal == 0 && checksDone > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // generous bound, the sequence needs about 350 cycles
  initial begin
    #300000;
    errTotal++;
    wrap_up;
  end
  initial begin
    tick(16);
    rst <= 1'b0;
    rd(`MEIS_IDX_MASK1, 8'hff);
    rd(`MEIS_IDX_MASK2, 8'hff);
    rd(`MEIS_IDX_CHMODE, 8'h00);
    rd(8'h00, 8'h00, 2'b10);
    diodeOpen <= 2'b01;
    diodeShort <= 2'b10;
    conv;
    rd(`MEIS_IDX_TEMP, 8'h7f);
    rd(`MEIS_IDX_DACOUT, 8'h00);
    rd(`MEIS_IDX_CAUSE2, 8'h40);
    rd(`MEIS_IDX_CAUSE2, 8'h00);
    diodeOpen <= 2'b00;
    diodeShort <= 2'b00;
    conv;
    rd(`MEIS_IDX_TEMP, 8'h55);
    wr(`MEIS_IDX_CFG1, 8'h02);
    wr(`MEIS_IDX_MASK2, 8'hef);
    intrude <= 1'b1;
    intIs(1'b0);
    intrude <= 1'b0;
    rd(`MEIS_IDX_CAUSE2, 8'h10);
    wr(`MEIS_IDX_CICLR, 8'h80);
    tick(PULSE + 5);
    `CHK("ciLine", 1'b0, chassisIntrusionIn)
    rd(`MEIS_IDX_CICLR, 8'h00);
    rd(`MEIS_IDX_CAUSE2, 8'h10);
    rd(`MEIS_IDX_CAUSE2, 8'h00);
    intIs(1'b1);
    wr(`MEIS_IDX_DACSET, 8'h35);
    wr(`MEIS_IDX_MASK2, 8'hff);
    extHot <= 1'b1;
    intIs(1'b1);
    `CHK("dacOut", 8'hff, dacOut)
    extHot <= 1'b0;
    tick(5);
    `CHK("dacOut", 8'h35, dacOut)
    rd(`MEIS_IDX_DACSET, 8'h35);
    rd(`MEIS_IDX_CAUSE2, 8'h20);
    limitOverheat <= 1'b1;
    tick(3);
    `CHK("ohLine", 1'b0, overheatLineIn)
    limitOverheat <= 1'b0;
    tick(5);
    `CHK("dacOut", 8'h35, dacOut)
    rd(`MEIS_IDX_CAUSE2, 8'h00);
    // masks stay all ones: they must not hide requests
    for (int i = 0; i < 3; i++) begin
      reqLevel <= 5'b00111 & ~(5'b1 << i);
      wr(`MEIS_IDX_CHMODE, 8'h1 << i);
      intIs(1'b0);
      rd(`MEIS_IDX_VIDST, {3'h0, 5'b00111 & ~(5'b1 << i)});
      rd(`MEIS_IDX_CAUSE1, 8'h00);
      wr(`MEIS_IDX_CHMODE, 8'h80 | (8'h1 << i));
      intIs(1'b1);
    end
    for (int i = 3; i < 5; i++) begin
      reqLevel <= 5'b00111 | (5'b1 << i);
      wr(`MEIS_IDX_CHMODE, 8'h1 << i);
      intIs(1'b1);
      wr(`MEIS_IDX_CFG2, 8'h1 << (i + 1));
      intIs(1'b0);
      wr(`MEIS_IDX_CFG1, 8'h0a);
      intIs(1'b1);
      wr(`MEIS_IDX_CFG1, 8'h00);
      intIs(1'b1);
      wr(`MEIS_IDX_CFG1, 8'h02);
      wr(`MEIS_IDX_CFG2, 8'h00);
      intIs(1'b1);
    end
    wr(`MEIS_IDX_CHMODE, 8'h01);
    clkEn <= 1'b0;
    reqLevel <= 5'b00110;
    tick(6);
    `CHK("intOut_n", 1'b1, intOut_n)
    clkEn <= 1'b1;
    intIs(1'b0);
    wrap_up;
  end
endmodule // tb_top
